// *** verilog/pma_regs_pkg.sv ***
// Purpose: constants and types for the single-pair pma management register slice
// Assumes: clause 45 style 16-bit register access, device address 0x01
// Notes:   offsets, field positions and reset values live here only
//
// Notes on behaviour
// R1 - ability register is read only; writes never change it
// R2 - ability bit 2 always reads 1, long-reach supported
// R3 - ability bits 3, 1 and 0 always read 0
// R4 - ability register resets to 0x0004
// R5 - control bit 14 set makes the device leader, clear makes it follower
// R6 - leader bit used only with autoneg off; strap sets its reset value
// R7 - type field bits 3:0: 0011 short, 0010 long, 0000 fast; 1xxx, 01xx reserved
// R8 - type field applied only with autoneg off and forced mode; software writes 0010
// R9 - control register resets to 0x8002 apart from leader bit, bit 15 reads 1
// R10 - pma control bit 14 set suppresses transmit output
// R11 - pma control bit 12 set selects 2.4 V p-p, clear selects 1.0 V p-p
// R12 - amplitude bit used only with autoneg off; strap sets its reset value
// R13 - pma control bit 0 set loops transmit data back to receive
// R14 - pma control resets to 0x0000 apart from amplitude bit; eee starts clear
// R15 - reserved bits read their reset value; read-only reserved bits ignore writes
package pma_regs_pkg;

  //------------------------------------------------------------
  // register map
  //------------------------------------------------------------
  localparam logic [4:0]  DEV_PMA          = 5'h01;
  localparam logic [15:0] ADDR_ABILITY     = 16'h0012;
  localparam logic [15:0] ADDR_PAIR_CTRL   = 16'h0834;
  localparam logic [15:0] ADDR_LR_PMA_CTRL = 16'h08f6;

  //------------------------------------------------------------
  // reset values and field positions
  //------------------------------------------------------------
  localparam logic [15:0] RST_ABILITY      = 16'h0004;
  localparam logic [15:0] RST_PAIR_CTRL    = 16'h8002;
  localparam logic [15:0] RST_LR_PMA_CTRL  = 16'h0000;
  localparam int          POS_LEADER       = 14;
  localparam int          POS_TX_OFF       = 14;
  localparam int          POS_AMP_HIGH     = 12;
  localparam int          POS_EEE          = 10;
  localparam int          POS_LOOPBACK     = 0;
  // writable bits: bit 15 of pma control is self clearing, bit 11 is plain r/w
  localparam logic [15:0] WMASK_PAIR_CTRL  = 16'h400f;
  localparam logic [15:0] WMASK_LR_PMA     = 16'h5c01;
  localparam logic [15:0] SC_LR_PMA        = 16'h8000;
  localparam logic [3:0]  VAR_SHORT        = 4'h3;
  localparam logic [3:0]  VAR_LONG         = 4'h2;
  localparam logic [3:0]  VAR_FAST         = 4'h0;

  // decoded single-pair variant
  typedef enum logic [3:0] {
    VARIANT_FAST     = 4'b0001,
    VARIANT_LONG     = 4'b0010,
    VARIANT_SHORT    = 4'b0100,
    VARIANT_RESERVED = 4'b1000
  } variant_t;

  // management request
  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [4:0]  devAddr;
    logic [15:0] regAddr;
    logic [15:0] wrData;
  } mgmt_req_t;

  // resolved pma settings handed to the transmit path
  typedef struct packed {
    logic     leader;
    variant_t variant;
    logic     txOff;
    logic     ampHigh;
    logic     eeeEnable;
    logic     loopback;
  } pma_cfg_t;

endpackage

// *** verilog/variant_decode.sv ***
// Purpose: decode of the single-pair variant select field
// Assumes: pure combinational, same clock as the caller
// Notes:   reserved codes map to their own state so callers can refuse them
`timescale 1ns/10ps
module variant_decode
  import pma_regs_pkg::*;
(
  input  wire logic [3:0] code,
  output variant_t        variant
);

  // 1xxx and 01xx fall to reserved, as do the unlisted 0001 // see R7
  assign variant = (code == VAR_SHORT) ? VARIANT_SHORT :
                   (code == VAR_LONG)  ? VARIANT_LONG  :
                   (code == VAR_FAST)  ? VARIANT_FAST  : VARIANT_RESERVED;

endmodule

// *** verilog/single_pair_pma_control_regs.sv ***
// Purpose: single-pair pma control and ability registers with resolved outputs
// Assumes: management requests arrive already framed on clk; straps are pins
// Notes:   autonegotiation results come in as same-clock inputs
`timescale 1ns/10ps
module single_pair_pma_control_regs
  import pma_regs_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire mgmt_req_t req,
  output logic [15:0]    rdData,
  output logic           rdValid,
  input  wire logic      strapLeader,
  input  wire logic      strapAmpHigh,
  input  wire logic      anEnable,
  input  wire logic      forcedLinkMode,
  input  wire logic      anLeader,
  input  wire logic      anAmpHigh,
  input  wire variant_t  anVariant,
  output pma_cfg_t       cfg
);

  //------------------------------------------------------------
  // strap synchronisers
  //------------------------------------------------------------
  logic [1:0] strapMeta_ff;
  logic [1:0] strapSync_ff;
  logic       strapTaken_ff;

  // straps come from pins, so two flops before anything reads them
  always_ff @(posedge clk) begin
    strapMeta_ff <= {strapLeader, strapAmpHigh};
    strapSync_ff <= strapMeta_ff;
  end

  //------------------------------------------------------------
  // address decode
  //------------------------------------------------------------
  logic isPma;
  logic hitPair;
  logic hitLrPma;
  logic hitAbility;
  logic wrPair;
  logic wrLrPma;

  assign isPma      = (req.devAddr == DEV_PMA);
  assign hitAbility = isPma && (req.regAddr == ADDR_ABILITY);
  assign hitPair    = isPma && (req.regAddr == ADDR_PAIR_CTRL);
  assign hitLrPma   = isPma && (req.regAddr == ADDR_LR_PMA_CTRL);
  assign wrPair     = req.wrEn && hitPair;
  assign wrLrPma    = req.wrEn && hitLrPma;

  //------------------------------------------------------------
  // register storage
  //------------------------------------------------------------
  logic [15:0] pairCtrl_ff;
  logic [15:0] lrPmaCtrl_ff;
  logic [15:0] nxt_pairCtrl;
  logic [15:0] nxt_lrPmaCtrl;
  logic [15:0] strapPair;
  logic [15:0] strapLrPma;

  // strap-dependent bits overlay the fixed reset words // see R6
  assign strapPair  = RST_PAIR_CTRL | (16'(strapSync_ff[1]) << POS_LEADER);
  assign strapLrPma = RST_LR_PMA_CTRL | (16'(strapSync_ff[0]) << POS_AMP_HIGH); // see R12

  // shared by both writable registers: read-only bits keep what they hold
  function automatic logic [15:0] maskedMerge(input logic [15:0] held,
                                              input logic [15:0] wdata,
                                              input logic [15:0] mask);
    return (held & ~mask) | (wdata & mask);
  endfunction

  // only masked bits take write data; reserved read-only bits keep reset value // see R15
  assign nxt_pairCtrl  = wrPair ? maskedMerge(pairCtrl_ff, req.wrData, WMASK_PAIR_CTRL)
                                : pairCtrl_ff; // see R9
  // self-clearing bit 15 never holds a written 1
  assign nxt_lrPmaCtrl = (wrLrPma ? maskedMerge(lrPmaCtrl_ff, req.wrData, WMASK_LR_PMA)
                                  : lrPmaCtrl_ff) & ~SC_LR_PMA; // see R14

  // reset loads the fixed words; straps are caught one cycle after release,
  // because a synchronous reset may not load a pin directly while it settles
  always_ff @(posedge clk) begin
    if (rst) begin
      pairCtrl_ff   <= RST_PAIR_CTRL; // see R9
      lrPmaCtrl_ff  <= RST_LR_PMA_CTRL; // see R14
      strapTaken_ff <= 1'b0;
    end else if (!strapTaken_ff) begin
      pairCtrl_ff   <= strapPair; // see R6
      lrPmaCtrl_ff  <= strapLrPma; // see R12
      strapTaken_ff <= 1'b1;
    end else begin
      pairCtrl_ff   <= nxt_pairCtrl;
      lrPmaCtrl_ff  <= nxt_lrPmaCtrl;
    end
  end

  //------------------------------------------------------------
  // read path
  //------------------------------------------------------------
  logic [15:0] nxt_rdData;

  // ability word is a constant: no storage, so no write can reach it // see R1
  assign nxt_rdData = hitAbility ? RST_ABILITY : // see R2 R4
                      hitPair    ? pairCtrl_ff :
                      hitLrPma   ? lrPmaCtrl_ff : 16'h0000; // see R3

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData  <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdData  <= req.rdEn ? nxt_rdData : rdData;
      rdValid <= req.rdEn;
    end
  end

  //------------------------------------------------------------
  // resolved settings
  //------------------------------------------------------------
  variant_t forcedVariant;
  pma_cfg_t nxt_cfg;
  logic     useForced;

  variant_decode u_variant_decode (
    .code    (pairCtrl_ff[3:0]),
    .variant (forcedVariant)
  );

  // type field counts only in forced mode; otherwise autoneg decides // see R8
  assign useForced = !anEnable && forcedLinkMode;

  assign nxt_cfg.leader    = anEnable ? anLeader : pairCtrl_ff[POS_LEADER]; // see R5
  assign nxt_cfg.variant   = useForced ? forcedVariant : anVariant; // see R7
  assign nxt_cfg.txOff     = lrPmaCtrl_ff[POS_TX_OFF]; // see R10
  assign nxt_cfg.ampHigh   = anEnable ? anAmpHigh : lrPmaCtrl_ff[POS_AMP_HIGH]; // see R11
  assign nxt_cfg.eeeEnable = lrPmaCtrl_ff[POS_EEE]; // see R14
  assign nxt_cfg.loopback  = lrPmaCtrl_ff[POS_LOOPBACK]; // see R13

  // registered so the transmit path sees glitch-free settings
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= '{leader: 1'b0, variant: VARIANT_LONG, txOff: 1'b0, ampHigh: 1'b0,
               eeeEnable: 1'b0, loopback: 1'b0};
    end else begin
      cfg <= nxt_cfg;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  a_ability_read_value: assert property (@(posedge clk) disable iff (rst) // see R2
    (req.rdEn && hitAbility) |=> (rdValid && rdData == 16'h0004))
    else $error("ability read did not return 0x0004");

  a_ability_unused_zero: assert property (@(posedge clk) disable iff (rst) // see R3
    (req.rdEn && hitAbility) |=> (rdData[3] == 1'b0 && rdData[1:0] == 2'b00))
    else $error("unsupported ability bits read nonzero");

  a_ability_after_write: assert property (@(posedge clk) disable iff (rst) // see R1
    (req.wrEn && hitAbility) ##[1:2] (req.rdEn && hitAbility) |=> (rdData == 16'h0004))
    else $error("write changed ability register");

  a_pair_reset_value: assert property (@(posedge clk) // see R9
    $past(rst) |-> (pairCtrl_ff == 16'h8002))
    else $error("control register not 0x8002 after reset");

  a_pma_reset_value: assert property (@(posedge clk) // see R14
    $past(rst) |-> (lrPmaCtrl_ff == 16'h0000))
    else $error("pma control not zero after reset");

  a_pair_rsvd_bits: assert property (@(posedge clk) disable iff (rst) // see R15
    strapTaken_ff |-> (pairCtrl_ff[15] == 1'b1 && pairCtrl_ff[13:4] == 10'h000))
    else $error("reserved control bits changed");

  a_leader_forced: assert property (@(posedge clk) disable iff (rst) // see R5
    (!anEnable && strapTaken_ff) |=> (cfg.leader == $past(pairCtrl_ff[14])))
    else $error("leader output does not follow control bit");

  a_leader_autoneg: assert property (@(posedge clk) disable iff (rst) // see R6
    anEnable |=> (cfg.leader == $past(anLeader)))
    else $error("leader output ignores autoneg role");

  a_txoff_write: assert property (@(posedge clk) disable iff (rst) // see R10
    (wrLrPma && strapTaken_ff) |=> ##1 (cfg.txOff == $past(req.wrData[14], 2)))
    else $error("transmit off did not follow write");

  a_amp_select: assert property (@(posedge clk) disable iff (rst) // see R11
    (!anEnable && strapTaken_ff) |=> (cfg.ampHigh == $past(lrPmaCtrl_ff[12])))
    else $error("amplitude does not follow control bit");

  a_amp_autoneg: assert property (@(posedge clk) disable iff (rst) // see R12
    anEnable |=> (cfg.ampHigh == $past(anAmpHigh)))
    else $error("amplitude ignores autoneg result");

  a_variant_forced: assert property (@(posedge clk) disable iff (rst) // see R8
    (!anEnable && forcedLinkMode && pairCtrl_ff[3:0] == 4'h2) |=> (cfg.variant == VARIANT_LONG))
    else $error("forced long-reach code not applied");

  a_variant_reserved: assert property (@(posedge clk) disable iff (rst) // see R7
    (useForced && pairCtrl_ff[3:2] != 2'b00) |=> (cfg.variant == VARIANT_RESERVED))
    else $error("reserved variant code not flagged");

  a_loopback_follow: assert property (@(posedge clk) disable iff (rst) // see R13
    strapTaken_ff |=> (cfg.loopback == $past(lrPmaCtrl_ff[0])))
    else $error("loopback does not follow control bit");

  a_eee_follow: assert property (@(posedge clk) disable iff (rst) // see R14
    strapTaken_ff |=> (cfg.eeeEnable == $past(lrPmaCtrl_ff[10])))
    else $error("energy-efficient enable does not follow control bit");

  a_pma_rsvd_bits: assert property (@(posedge clk) disable iff (rst) // see R15
    strapTaken_ff |-> (lrPmaCtrl_ff[15] == 1'b0 && lrPmaCtrl_ff[13] == 1'b0 && lrPmaCtrl_ff[9:1] == 9'h000))
    else $error("reserved pma control bits changed");

  a_unmapped_read: assert property (@(posedge clk) disable iff (rst) // see R15
    (req.rdEn && !hitAbility && !hitPair && !hitLrPma) |=> (rdValid && rdData == 16'h0000))
    else $error("unmapped read did not return zero");

  a_variant_autoneg: assert property (@(posedge clk) disable iff (rst) // see R8
    !useForced |=> (cfg.variant == $past(anVariant)))
    else $error("variant ignores autoneg result");

  a_txoff_follow: assert property (@(posedge clk) disable iff (rst) // see R10
    strapTaken_ff |=> (cfg.txOff == $past(lrPmaCtrl_ff[14])))
    else $error("transmit off does not follow control bit");

endmodule

// *** testbench/single_pair_pma_control_regs_tb_top.sv ***
// Purpose: self-checking bench for the single-pair pma register slice
// Assumes: clk at 200 MHz, synchronous active high reset, straps steady around reset
// Notes:   reset values first, then register rows, cfg fields, autoneg override, variant codes, straps
`timescale 1ns/10ps
module single_pair_pma_control_regs_tb_top;
  import pma_regs_pkg::*;

  //------------------------------------------------------------
  // signals and row table
  //------------------------------------------------------------
  logic        clk, rst, strapLeader, strapAmpHigh, anEnable, forcedLinkMode, anLeader, anAmpHigh;
  mgmt_req_t   req;
  variant_t    anVariant;
  logic [15:0] rdData;
  logic        rdValid;
  pma_cfg_t    cfg;
  int          errCount = 0;
  int          nChecks  = 0;
  int          cycles   = 0;
  typedef struct {logic [4:0] dev; logic [15:0] addr; logic [15:0] wdata; logic [15:0] exp;} row_t;
  // write one word, read it back at device 0x01; last two rows hit nothing
  row_t rows[7] = '{'{DEV_PMA, ADDR_ABILITY, 16'hffff, 16'h0004},
                    '{DEV_PMA, ADDR_PAIR_CTRL, 16'hffff, 16'hc00f},
                    '{DEV_PMA, ADDR_PAIR_CTRL, 16'h0002, 16'h8002},
                    '{DEV_PMA, ADDR_LR_PMA_CTRL, 16'hffff, 16'h5c01},
                    '{DEV_PMA, ADDR_LR_PMA_CTRL, 16'h0000, 16'h0000},
                    '{5'h03, ADDR_LR_PMA_CTRL, 16'h4000, 16'h0000},
                    '{DEV_PMA, 16'h0013, 16'hffff, 16'h0000}};
  logic [3:0]  codes[6]   = '{4'h3, 4'h0, 4'h8, 4'h4, 4'h1, 4'h2};
  variant_t    expVar[6]  = '{VARIANT_SHORT, VARIANT_FAST, VARIANT_RESERVED, VARIANT_RESERVED,
                              VARIANT_RESERVED, VARIANT_LONG};

  single_pair_pma_control_regs u_single_pair_pma_control_regs (
    .clk(clk), .rst(rst), .req(req), .rdData(rdData), .rdValid(rdValid),
    .strapLeader(strapLeader), .strapAmpHigh(strapAmpHigh), .anEnable(anEnable),
    .forcedLinkMode(forcedLinkMode), .anLeader(anLeader), .anAmpHigh(anAmpHigh),
    .anVariant(anVariant), .cfg(cfg)
  );

  //------------------------------------------------------------
  // clock, timeout and shared tasks
  //------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run is well under 500 cycles, so 3000 means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errCount++;
      $display("Error timeout expected finish seen hang");
      tallyAndFinish();
    end
  end

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp16(what, {15'h0, exp}, {15'h0, got});
  endtask

  // request held one cycle, dropped right after the taking edge
  task automatic wr(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk);
    req <= '{wrEn: 1'b1, rdEn: 1'b0, devAddr: dev, regAddr: addr, wrData: data};
    @(posedge clk);
    req.wrEn <= 1'b0;
  endtask

  // rdValid stands one cycle only, so it is looked at just after that edge
  task automatic rdChk(input logic [15:0] addr, input logic [15:0] exp);
    @(posedge clk);
    req <= '{wrEn: 1'b0, rdEn: 1'b1, devAddr: DEV_PMA, regAddr: addr, wrData: 16'h0};
    @(posedge clk);
    req.rdEn <= 1'b0;
    #1;
    cmp1("rdValid", 1'b1, rdValid);
    cmp16("rdData", exp, rdData);
  endtask

  // cfg trails the register by one edge
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic doReset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    rst            <= 1'b1;
    req            <= '0;
    strapLeader    <= 1'b0;
    strapAmpHigh   <= 1'b0;
    anEnable       <= 1'b0;
    forcedLinkMode <= 1'b1;
    anLeader       <= 1'b0;
    anAmpHigh      <= 1'b0;
    anVariant      <= VARIANT_SHORT;
    doReset();
    rdChk(ADDR_ABILITY, 16'h0004);
    rdChk(ADDR_PAIR_CTRL, 16'h8002);
    rdChk(ADDR_LR_PMA_CTRL, 16'h0000);
    cmp16("cfg", {7'h0, 1'b0, VARIANT_LONG, 4'h0}, {7'h0, cfg});
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(rows[i].dev, rows[i].addr, rows[i].wdata);
      rdChk(rows[i].addr, rows[i].exp);
    end
    $display("test register rows done");
    wr(DEV_PMA, ADDR_LR_PMA_CTRL, 16'h5c01);
    wr(DEV_PMA, ADDR_PAIR_CTRL, 16'h4002);
    settle();
    cmp16("cfg", {7'h0, 1'b1, VARIANT_LONG, 4'hf}, {7'h0, cfg});
    wr(DEV_PMA, ADDR_LR_PMA_CTRL, 16'h0000);
    settle();
    cmp16("cfg", {7'h0, 1'b1, VARIANT_LONG, 4'h0}, {7'h0, cfg});
    $display("test cfg fields done");
    // autoneg owns role, amplitude and variant; the register values must lose
    wr(DEV_PMA, ADDR_LR_PMA_CTRL, 16'h1000);
    @(posedge clk);
    anEnable <= 1'b1;
    settle();
    cmp1("leader", 1'b0, cfg.leader);
    cmp1("ampHigh", 1'b0, cfg.ampHigh);
    cmp16("variant", {12'h0, VARIANT_SHORT}, {12'h0, cfg.variant});
    @(posedge clk);
    anEnable <= 1'b0;
    settle();
    cmp1("ampHigh", 1'b1, cfg.ampHigh);
    $display("test autoneg override done");
    foreach (codes[i]) begin
      wr(DEV_PMA, ADDR_PAIR_CTRL, {12'h000, codes[i]});
      settle();
      cmp16("variant", {12'h0, expVar[i]}, {12'h0, cfg.variant});
    end
    @(posedge clk);
    forcedLinkMode <= 1'b0;
    settle();
    cmp16("variant", {12'h0, VARIANT_SHORT}, {12'h0, cfg.variant});
    $display("test variant codes done");
    @(posedge clk);
    strapLeader  <= 1'b1;
    strapAmpHigh <= 1'b1;
    doReset();
    rdChk(ADDR_PAIR_CTRL, 16'hc002);
    rdChk(ADDR_LR_PMA_CTRL, 16'h1000);
    rdChk(ADDR_ABILITY, 16'h0004);
    $display("test strap reset done");
    tallyAndFinish();
  end
endmodule
